// ---- include/dac_cfg.svh ----
// constants for the deferred address and configuration decoder
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH
`define DAC_Y_LSB 0
`define DAC_Y_W 17
`define DAC_DEFER_BIT 17
`define DAC_J_LSB 18
`define DAC_J_W 6
`define DAC_OP_LSB 24
`define DAC_OP_W 6
`define DAC_CF_LSB 30
`define DAC_CF_W 5
`define DAC_HOLD_BIT 35
`define DAC_CFW_PERM_LSB 0
`define DAC_CFW_ACT_LSB 3
`define DAC_CFW_CPL_LSB 7
`define DAC_REG_CTRL 6'h00
`define DAC_REG_STATUS 6'h01
`define DAC_REG_IADDR 6'h02
`define DAC_REG_OPADDR 6'h03
`define DAC_REG_OPCODES 6'h04
`define DAC_REG_IDX 6'h05
`define DAC_REG_CFG 6'h06
`define DAC_REG_OPND_LO 6'h07
`define DAC_REG_OPND_HI 6'h08
`define DAC_TBL_ADDR_LSB 24
`define DAC_RST_IADDR 17'h00000
`endif

// ---- include/dac_pkg.sv ----
// types shared by the decoder and the exchange reshaper
package dac_pkg;
	typedef enum logic [3:0] {
		DAC_IDLE, DAC_IFETCH, DAC_DFETCH, DAC_IDX, DAC_IDXWB,
		DAC_CFG, DAC_EXEC, DAC_ORD, DAC_OWR
	} dac_state_e;
	typedef logic [35:0] dac_word_t;
	typedef logic [8:0] dac_cfgw_t;
endpackage

// ---- rtl/dac_xchg.sv ----
// exchange path: quarter permutation, sign extension, arithmetic config
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"
module dac_xchg
	import dac_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic load,
	input wire logic sext_en,
	input wire dac_word_t data_in,
	input wire dac_cfgw_t cfg_word,
	output dac_word_t data_out,
	output logic [5:0] arith_cfg
);
	function automatic logic split_at(input logic [1:0] cp, input int i);
		split_at = (i == 0) || (cp == 2'b11) || (cp == 2'b01 && i == 2) ||
			(cp == 2'b10 && i == 1);
	endfunction

	function automatic dac_word_t permute(input dac_word_t d, input logic [2:0] p);
		logic [8:0] q0, q1, q2, q3;
		q0 = d[8:0];
		q1 = d[17:9];
		q2 = d[26:18];
		q3 = d[35:27];
		case (p)
			3'h1: permute = {q1, q0, q3, q2};
			3'h2: permute = {q2, q3, q0, q1};
			3'h3: permute = {q0, q1, q2, q3};
			3'h4: permute = {q2, q1, q0, q3};
			3'h5: permute = {q0, q3, q2, q1};
			3'h6: permute = {q3, q2, q0, q1};
			3'h7: permute = {q2, q3, q1, q0};
			default: permute = d;
		endcase
	endfunction

	function automatic dac_word_t sign_ext(input dac_word_t d, input logic [1:0] cp,
			input logic [3:0] act_n);
		logic have;
		logic s;
		dac_word_t r;
		have = 1'b0;
		s = 1'b0;
		r = d;
		for (int i = 0; i < 4; i++) begin
			if (split_at(cp, i))
				have = 1'b0;
			if (!act_n[i]) begin
				s = d[i*9+8];
				have = 1'b1;
			end else if (have) begin
				r[i*9 +: 9] = {9{s}};
			end
		end
		sign_ext = r;
	endfunction

	function automatic logic [3:0] force_act(input logic [1:0] cp, input logic [3:0] act_n);
		logic [3:0] r;
		logic any;
		r = act_n;
		for (int i = 0; i < 4; i++) begin
			any = 1'b0;
			for (int j = 0; j < 4; j++) begin
				if (!act_n[j] && same_sub(cp, i, j))
					any = 1'b1;
			end
			r[i] = !any;
		end
		force_act = r;
	endfunction

	function automatic logic same_sub(input logic [1:0] cp, input int a, input int b);
		logic r;
		r = 1'b1;
		for (int k = 1; k < 4; k++) begin
			if (split_at(cp, k) && ((a < k) != (b < k)))
				r = 1'b0;
		end
		same_sub = r;
	endfunction

	wire logic [1:0] cpl = cfg_word[`DAC_CFW_CPL_LSB +: 2];
	wire logic [3:0] act_n = cfg_word[`DAC_CFW_ACT_LSB +: 4];
	wire logic [2:0] perm = cfg_word[`DAC_CFW_PERM_LSB +: 3];
	wire dac_word_t permuted = permute(data_in, perm);
	wire dac_word_t extended = sext_en ? sign_ext(permuted, cpl, act_n) : permuted;
	// no permutation in the arithmetic config, subwords forced all-or-none
	wire logic [5:0] next_arith_cfg = {cpl, force_act(cpl, act_n)};

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			data_out <= 36'h0;
			arith_cfg <= 6'h00;
		end else if (load) begin
			data_out <= extended;
			arith_cfg <= next_arith_cfg;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/dac_decoder.sv ----
// deferred address chaining, indexing, op staging and config decoder
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"
module dac_decoder
	import dac_pkg::*;
#(
	parameter int AW = 17,
	parameter int IDX_N = 64,
	parameter int CFG_N = 32
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic mem_req,
	output logic mem_we,
	output logic [AW-1:0] mem_addr,
	output dac_word_t mem_wdata,
	input wire logic mem_done,
	input wire dac_word_t mem_rdata,
	input wire logic jump_ok,
	input wire dac_word_t arith_result,
	output dac_word_t operand_out,
	output logic operand_valid,
	output logic [1:0] operand_dest,
	output logic [5:0] arith_cfg,
	output logic [5:0] opcode_program_stage,
	output logic [5:0] opcode_operand_stage,
	output logic [5:0] opcode_arith_stage
);
	function automatic logic op_is_jump(input logic [5:0] op);
		op_is_jump = (op[5:3] == 3'h7);
	endfunction

	function automatic logic op_is_store(input logic [5:0] op);
		op_is_store = op[3] && !op_is_jump(op);
	endfunction

	function automatic logic op_needs_opnd(input logic [5:0] op);
		op_needs_opnd = (op != 6'h00) && !op_is_jump(op);
	endfunction

	dac_state_e st;
	dac_state_e next_st;
	logic run;
	logic ack;
	logic defer_active;
	logic hold_bit_latch;
	logic [4:0] config_select_latch;
	dac_cfgw_t config_word_buffer;
	dac_word_t nbuf;
	dac_word_t wdata;
	logic [AW-1:0] iaddr;
	logic [AW-1:0] opaddr;
	logic [AW-1:0] xreg;
	logic [AW-1:0] final_addr;
	logic [5:0] idx_sel;
	logic [4:0] cfg_sel;
	logic xchg_load;
	logic [AW-1:0] idx_mem [0:IDX_N-1];
	dac_cfgw_t cfg_mem [0:CFG_N-1];

	// instruction buffer and read data fields
	wire logic [AW-1:0] n_y = nbuf[`DAC_Y_LSB +: `DAC_Y_W];
	wire logic n_defer = nbuf[`DAC_DEFER_BIT];
	wire logic [5:0] n_j = nbuf[`DAC_J_LSB +: `DAC_J_W];
	wire logic [AW-1:0] r_y = mem_rdata[`DAC_Y_LSB +: `DAC_Y_W];
	wire logic r_defer = mem_rdata[`DAC_DEFER_BIT];
	wire logic [5:0] r_j = mem_rdata[`DAC_J_LSB +: `DAC_J_W];

	// index adder and register-zero wiring
	wire logic [AW-1:0] idx_rd = (n_j == 6'h00) ? '0 : idx_mem[n_j];
	wire logic [AW-1:0] eff = AW'(n_y + xreg);
	wire dac_cfgw_t cfg_rd = (config_select_latch == 5'h00) ? '0 :
		cfg_mem[config_select_latch];

	wire logic mem_st = (st == DAC_IFETCH) || (st == DAC_DFETCH) ||
		(st == DAC_ORD) || (st == DAC_OWR);
	wire logic step = mem_st && mem_done;
	wire dac_state_e after_instr = run ? DAC_IFETCH : DAC_IDLE;
	wire logic op_jump = op_is_jump(opcode_program_stage);
	wire logic op_store = op_is_store(opcode_operand_stage);

	// bus decode; tables and the address take bus writes only while stopped
	wire logic bus_req = avs_read || avs_write;
	wire logic [5:0] reg_idx = avs_address[7:2];
	wire logic stopped = (st == DAC_IDLE) && !run;
	wire logic wr_ok = avs_write && ack && (avs_byteenable == 4'hF);
	wire logic wr_ctrl = wr_ok && (reg_idx == `DAC_REG_CTRL);
	wire logic wr_iaddr = wr_ok && stopped && (reg_idx == `DAC_REG_IADDR);
	wire logic wr_idx = wr_ok && stopped && (reg_idx == `DAC_REG_IDX);
	wire logic wr_cfg = wr_ok && stopped && (reg_idx == `DAC_REG_CFG);
	wire logic [5:0] bus_idx_a = avs_writedata[`DAC_TBL_ADDR_LSB +: 6];
	wire logic [4:0] bus_cfg_a = avs_writedata[`DAC_TBL_ADDR_LSB +: 5];
	wire logic idx_wb = (st == DAC_IDXWB) && (n_j != 6'h00);
	wire logic idx_we = idx_wb || wr_idx;
	wire logic [5:0] idx_wa = idx_wb ? n_j : bus_idx_a;
	wire logic [AW-1:0] idx_wd = idx_wb ? xreg : avs_writedata[AW-1:0];
	wire logic [AW-1:0] idx_view = (idx_sel == 6'h00) ? '0 : idx_mem[idx_sel];
	wire dac_cfgw_t cfg_view = (cfg_sel == 5'h00) ? '0 : cfg_mem[cfg_sel];

	logic [31:0] rd_mux;
	always_comb begin
		case (reg_idx)
			`DAC_REG_CTRL: rd_mux = {31'h0, run};
			`DAC_REG_STATUS: rd_mux = {24'h0, 4'(st), hold_bit_latch,
				defer_active, run, st != DAC_IDLE};
			`DAC_REG_IADDR: rd_mux = 32'(iaddr);
			`DAC_REG_OPADDR: rd_mux = 32'(opaddr);
			`DAC_REG_OPCODES: rd_mux = {9'h0, config_select_latch,
				opcode_arith_stage, opcode_operand_stage, opcode_program_stage};
			`DAC_REG_IDX: rd_mux = 32'(idx_view);
			`DAC_REG_CFG: rd_mux = 32'(cfg_view);
			`DAC_REG_OPND_LO: rd_mux = operand_out[31:0];
			`DAC_REG_OPND_HI: rd_mux = {18'h0, arith_cfg, 4'h0, operand_out[35:32]};
			default: rd_mux = 32'h0;
		endcase
	end

	assign avs_waitrequest = bus_req && !ack;
	assign mem_req = mem_st;
	assign mem_we = (st == DAC_OWR);
	assign mem_addr = (st == DAC_IFETCH) ? iaddr : opaddr;
	assign mem_wdata = wdata;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ack <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			ack <= bus_req && !ack;
			if (avs_read && !ack)
				avs_readdata <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (idx_we)
			idx_mem[idx_wa] <= idx_wd;
		if (wr_cfg)
			cfg_mem[bus_cfg_a] <= avs_writedata[8:0];
	end

	always_comb begin
		next_st = st;
		case (st)
			DAC_IDLE: if (run) next_st = DAC_IFETCH;
			DAC_IFETCH: if (step) next_st = r_defer ? DAC_DFETCH : DAC_IDX;
			DAC_DFETCH: if (step) next_st = DAC_IDX;
			DAC_IDX: next_st = DAC_IDXWB;
			DAC_IDXWB: if (defer_active && n_defer) next_st = DAC_DFETCH;
				else if (defer_active) next_st = DAC_IDX;
				else next_st = DAC_CFG;
			DAC_CFG: next_st = DAC_EXEC;
			DAC_EXEC: if (op_jump) next_st = after_instr;
				else if (op_needs_opnd(opcode_program_stage)) next_st = DAC_ORD;
				else next_st = after_instr;
			DAC_ORD: if (step) next_st = DAC_OWR;
			DAC_OWR: if (step) next_st = after_instr;
			default: next_st = DAC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st <= DAC_IDLE;
			run <= 1'b0;
			idx_sel <= 6'h00;
			cfg_sel <= 5'h00;
		end else begin
			st <= next_st;
			if (wr_ctrl)
				run <= avs_writedata[0];
			if (wr_idx)
				idx_sel <= bus_idx_a;
			if (wr_cfg)
				cfg_sel <= bus_cfg_a;
		end
	end

	// instruction fetch, deferred chain and indexing
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			iaddr <= `DAC_RST_IADDR;
			opaddr <= '0;
			nbuf <= 36'h0;
			xreg <= '0;
			final_addr <= '0;
			defer_active <= 1'b0;
			hold_bit_latch <= 1'b0;
			config_select_latch <= 5'h00;
			opcode_program_stage <= 6'h00;
		end else begin
			if (wr_iaddr)
				iaddr <= avs_writedata[AW-1:0];
			if (st == DAC_IFETCH && mem_done) begin
				nbuf <= mem_rdata;
				iaddr <= AW'(iaddr + 1'b1);
				// only here, so deferred words never disturb them
				hold_bit_latch <= mem_rdata[`DAC_HOLD_BIT];
				config_select_latch <= mem_rdata[`DAC_CF_LSB +: `DAC_CF_W];
				opcode_program_stage <= mem_rdata[`DAC_OP_LSB +: `DAC_OP_W];
				if (r_defer) begin
					opaddr <= r_y;
					defer_active <= 1'b1;
				end
			end
			if (st == DAC_DFETCH && mem_done)
				nbuf[`DAC_J_LSB +: `DAC_J_W] <= mem_rdata[`DAC_J_LSB +: `DAC_J_W];
			if (st == DAC_DFETCH && mem_done)
				nbuf[`DAC_Y_LSB +: 18] <= mem_rdata[`DAC_Y_LSB +: 18];
			if (st == DAC_IDX)
				xreg <= idx_rd;
			if (st == DAC_IDXWB) begin
				if (defer_active && n_defer) begin
					opaddr <= eff;
				end else if (defer_active) begin
					nbuf[`DAC_Y_LSB +: `DAC_Y_W] <= eff;
					nbuf[`DAC_J_LSB +: `DAC_J_W] <= config_word_buffer[5:0];
					defer_active <= 1'b0;
				end else begin
					final_addr <= eff;
				end
			end
			if (st == DAC_EXEC) begin
				if (op_jump && jump_ok)
					iaddr <= final_addr;
				else if (!op_jump && op_needs_opnd(opcode_program_stage))
					opaddr <= final_addr;
			end
		end
	end

	// config buffer doubles as the parking place for the index field
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			config_word_buffer <= 9'h000;
			opcode_operand_stage <= 6'h00;
			opcode_arith_stage <= 6'h00;
		end else begin
			if (st == DAC_IFETCH && mem_done && r_defer)
				config_word_buffer <= {3'h0, r_j};
			if (st == DAC_CFG) begin
				config_word_buffer <= cfg_rd;
				opcode_operand_stage <= opcode_program_stage;
			end
			if (st == DAC_ORD && mem_done)
				opcode_arith_stage <= opcode_operand_stage;
		end
	end

	// operand read and rewrite
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wdata <= 36'h0;
			xchg_load <= 1'b0;
			operand_valid <= 1'b0;
			operand_dest <= 2'h0;
		end else begin
			xchg_load <= (st == DAC_ORD) && mem_done;
			operand_valid <= xchg_load;
			if (st == DAC_ORD && mem_done) begin
				wdata <= op_store ? arith_result : mem_rdata;
				operand_dest <= opcode_operand_stage[5:4];
			end
		end
	end

	// hold the raw operand so the reshaper sees it with the config word
	dac_word_t obuf;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			obuf <= 36'h0;
		else if (st == DAC_ORD && mem_done)
			obuf <= mem_rdata;
	end

	dac_xchg u_xchg (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.load(xchg_load),
		.sext_en(!op_store),
		.data_in(obuf),
		.cfg_word(config_word_buffer),
		.data_out(operand_out),
		.arith_cfg(arith_cfg)
	);
endmodule
`default_nettype wire

// ---- test/dac_decoder_assertions.sv ----
// port checker for the deferred address and configuration decoder
`timescale 1ns/1ps
`default_nettype none
module dac_decoder_assertions #(
	parameter int AW = 17
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [AW-1:0] mem_addr,
	input wire logic mem_done,
	input wire logic operand_valid,
	input wire logic [1:0] operand_dest,
	input wire logic [5:0] arith_cfg,
	input wire logic [5:0] opcode_program_stage,
	input wire logic [5:0] opcode_operand_stage
);
	logic rd_done;
	assign rd_done = mem_done & mem_req & ~mem_we;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_req_held: assert property (
		mem_req && !mem_done |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request dropped before completion");
	a_we_in_cycle: assert property (mem_we |-> mem_req)
		else $error("write strobe outside a memory cycle");
	a_rewrite_addr: assert property ($rose(mem_we) |-> mem_addr == $past(mem_addr))
		else $error("rewrite not aimed at the operand location");
	a_valid_after_read: assert property (operand_valid |-> $past(rd_done, 2))
		else $error("operand presented without a completed read");
	a_valid_pulse: assert property (operand_valid |=> !operand_valid)
		else $error("operand valid longer than one cycle");
	a_dest_follows: assert property (
		operand_valid |-> operand_dest == opcode_operand_stage[5:4])
		else $error("operand routed to wrong unit");
	a_op_copy: assert property (
		$changed(opcode_operand_stage) |-> opcode_operand_stage == $past(opcode_program_stage))
		else $error("operand stage opcode not copied from program stage");
	a_arith_full: assert property (
		arith_cfg[5:4] == 2'h0 |-> arith_cfg[3:0] == 4'h0 || arith_cfg[3:0] == 4'hF)
		else $error("whole word partly active in arithmetic config");
	a_arith_pair: assert property (
		arith_cfg[5:4] == 2'h1 |-> arith_cfg[3] == arith_cfg[2] && arith_cfg[1] == arith_cfg[0])
		else $error("half word partly active in arithmetic config");
endmodule
bind dac_decoder dac_decoder_assertions #(.AW(AW)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
	.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_done(mem_done),
	.operand_valid(operand_valid), .operand_dest(operand_dest), .arith_cfg(arith_cfg),
	.opcode_program_stage(opcode_program_stage), .opcode_operand_stage(opcode_operand_stage));
`default_nettype wire

// ---- test/dac_mem_model.sv ----
// memory unit model answering fetch, operand and rewrite cycles
`timescale 1ns/1ps
`default_nettype none
module dac_mem_model
	import dac_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [16:0] mem_addr,
	input wire dac_word_t mem_wdata,
	input wire logic [2:0] lat,
	output logic mem_done,
	output dac_word_t mem_rdata
);
	dac_word_t mem [4096];
	logic [2:0] cnt;
	// data toggles outside a completed read so stale words never pass
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 3'h0;
			mem_done <= 1'b0;
			mem_rdata <= 36'h0;
		end else begin
			mem_done <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_done) begin
				cnt <= cnt + 3'h1;
				if (cnt + 3'h1 >= lat) begin
					cnt <= 3'h0;
					mem_done <= 1'b1;
					if (mem_we) mem[mem_addr[11:0]] <= mem_wdata;
					else mem_rdata <= mem[mem_addr[11:0]];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- test/tb_dac_decoder.sv ----
// self-checking bench for the deferred address and configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg.svh"
module tb_dac_decoder;
	import dac_pkg::*;
	typedef struct {dac_word_t w; logic [1:0] d; logic a; logic [5:0] c;} dac_exp_s;
	logic clk_sys = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, jump_ok = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rq;
	logic [3:0] avs_byteenable = 4'hF;
	logic avs_waitrequest, mem_req, mem_we, mem_done, operand_valid;
	logic [16:0] mem_addr;
	dac_word_t mem_wdata, mem_rdata, operand_out, arith_result = 36'h0, w [8];
	logic [1:0] operand_dest;
	logic [5:0] arith_cfg, ops_p, ops_q, ops_a;
	logic [2:0] lat = 3'h1;
	int n_errors = 0, comparisons = 0, n_seen = 0;
	dac_exp_s exp_q [$];
	always #20 clk_sys = ~clk_sys;
	dac_decoder uut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_done(mem_done), .mem_rdata(mem_rdata),
		.jump_ok(jump_ok), .arith_result(arith_result), .operand_out(operand_out),
		.operand_valid(operand_valid), .operand_dest(operand_dest), .arith_cfg(arith_cfg),
		.opcode_program_stage(ops_p), .opcode_operand_stage(ops_q), .opcode_arith_stage(ops_a));
	dac_mem_model mem_model (.clk_sys(clk_sys), .arst_n(arst_n), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
		.mem_done(mem_done), .mem_rdata(mem_rdata));
	task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] ex);
		comparisons++;
		if (seen !== ex) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic bus(input logic wr, input logic [5:0] ix, input logic [31:0] d,
		input logic [3:0] be);
		avs_address <= {ix, 2'b00};
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rq = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [5:0] ix, input logic [31:0] ex, input string nm);
		bus(1'b0, ix, 32'h0, 4'hF);
		chk(nm, {4'h0, rq}, {4'h0, ex});
	endtask
	task automatic final_report;
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic dac_word_t ins(logic [4:0] cf, logic [5:0] op, logic [5:0] j,
		logic df, logic [16:0] y);
		return {1'b0, cf, op, j, df, y};
	endfunction
	// results are taken in order; anything unannounced is a skipped jump or stray cycle
	always @(posedge clk_sys) begin
		if (operand_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("extra operand", 36'h1, 36'h0);
			end else begin
				chk("operand", operand_out, exp_q[0].w);
				chk("dest", 36'(operand_dest), 36'(exp_q[0].d));
				if (exp_q[0].a) chk("arith_cfg", 36'(arith_cfg), 36'(exp_q[0].c));
				void'(exp_q.pop_front());
			end
			n_seen++;
		end
	end
	initial begin
		#400000;
		n_errors++;
		final_report();
	end
	initial begin
		int unsigned oa [7] = '{'h100, 'h110, 'h407, 'h500, 'h600, 'h700, 'h800};
		logic [16:0] xv [4] = '{17'h0, 17'h10, 17'h5, 17'h2};
		void'($urandom(32'hBF3F));
		for (int i = 0; i < 8; i++) w[i] = 36'({$urandom(), $urandom()});
		w[4][8] = 1'b1;
		w[6][8] = 1'b1;
		arith_result = 36'({$urandom(), $urandom()});
		lat = 3'($urandom_range(2, 4));
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		rd(`DAC_REG_CTRL, 32'h0, "ctrl reset");
		rd(`DAC_REG_STATUS, 32'h0, "status reset");
		rd(`DAC_REG_IADDR, 32'h0, "iaddr reset");
		bus(1'b1, `DAC_REG_CTRL, 32'h1, 4'h3);
		rd(`DAC_REG_CTRL, 32'h0, "ctrl partial write");
		bus(1'b1, `DAC_REG_OPADDR, 32'h123, 4'hF);
		rd(`DAC_REG_OPADDR, 32'h0, "opaddr read only");
		rd(6'h3F, 32'h0, "unmapped");
		for (int i = 1; i < 4; i++) bus(1'b1, `DAC_REG_IDX, 32'(i << 24) | 32'(xv[i]), 4'hF);
		bus(1'b1, `DAC_REG_CFG, {3'h0, 5'h01, 15'h0, 9'h070}, 4'hF);
		bus(1'b1, `DAC_REG_CFG, {3'h0, 5'h02, 15'h0, 9'h0F0}, 4'hF);
		rd(`DAC_REG_IDX, 32'h2, "index readback");
		for (int i = 0; i < 7; i++) mem_model.mem[oa[i]] = w[i];
		mem_model.mem[0] = ins(5'h00, 6'h11, 6'h00, 1'b0, 17'h100);
		mem_model.mem[1] = ins(5'h00, 6'h21, 6'h01, 1'b0, 17'h100);
		mem_model.mem[2] = ins(5'h00, 6'h31, 6'h02, 1'b1, 17'h200);
		// chained words carry junk opcode and config that must be ignored
		mem_model.mem['h200] = ins(5'h1F, 6'h0A, 6'h01, 1'b1, 17'h300);
		mem_model.mem['h310] = ins(5'h1F, 6'h0A, 6'h03, 1'b0, 17'h400);
		mem_model.mem[3] = ins(5'h00, 6'h09, 6'h00, 1'b0, 17'h500);
		mem_model.mem[4] = ins(5'h01, 6'h11, 6'h00, 1'b0, 17'h600);
		mem_model.mem[5] = ins(5'h00, 6'h38, 6'h00, 1'b0, 17'h20);
		mem_model.mem[6] = ins(5'h00, 6'h01, 6'h00, 1'b0, 17'h700);
		mem_model.mem[7] = ins(5'h00, 6'h38, 6'h00, 1'b0, 17'hA);
		mem_model.mem[8] = ins(5'h00, 6'h01, 6'h00, 1'b0, 17'h900);
		mem_model.mem[9] = mem_model.mem[8];
		mem_model.mem['hA] = ins(5'h02, 6'h11, 6'h00, 1'b0, 17'h800);
		mem_model.mem['hB] = ins(5'h00, 6'h01, 6'h00, 1'b0, 17'h100);
		// jump-to-self parks the decoder until run is cleared, no unwritten fetch
		mem_model.mem['hC] = ins(5'h00, 6'h38, 6'h00, 1'b0, 17'hC);
		exp_q.push_back('{w[0], 2'h1, 1'b1, 6'h00});
		exp_q.push_back('{w[1], 2'h2, 1'b0, 6'h00});
		exp_q.push_back('{w[2], 2'h3, 1'b0, 6'h00});
		exp_q.push_back('{w[3], 2'h0, 1'b0, 6'h00});
		exp_q.push_back('{{{27{w[4][8]}}, w[4][8:0]}, 2'h1, 1'b1, 6'h00});
		exp_q.push_back('{w[5], 2'h0, 1'b0, 6'h00});
		exp_q.push_back('{{w[6][35:18], {9{w[6][8]}}, w[6][8:0]}, 2'h1, 1'b1, 6'h1C});
		exp_q.push_back('{w[0], 2'h0, 1'b0, 6'h00});
		bus(1'b1, `DAC_REG_IADDR, 32'h0, 4'hF);
		bus(1'b1, `DAC_REG_CTRL, 32'h1, 4'hF);
		wait (n_seen >= 6);
		jump_ok <= 1'b1;
		lat <= 3'h1;
		wait (n_seen >= 8);
		bus(1'b1, `DAC_REG_CTRL, 32'h0, 4'hF);
		do bus(1'b0, `DAC_REG_STATUS, 32'h0, 4'hF); while (rq[0] !== 1'b0);
		chk("store result", mem_model.mem['h500], arith_result);
		chk("load rewrite", mem_model.mem['h100], w[0]);
		rd(`DAC_REG_IDX, 32'h2, "index unchanged");
		rd(`DAC_REG_IADDR, 32'hC, "jump loop address");
		rd(`DAC_REG_OPCODES, 32'h1E38, "opcode stages");
		chk("arith stage", 36'(ops_a), 36'h01);
		chk("program stage", 36'(ops_p), 36'h38);
		chk("pending results", 36'(exp_q.size()), 36'h0);
		final_report();
	end
endmodule
`default_nettype wire
